/* File: src/spdl_core.sv */
// Speed reference limiter, overspeed fault and speed status outputs with a Wishbone slave.
// Assumes speed feedback, speed reference and analog samples come from logic on clk_i.
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Overspeed fault above min(threshold, 1.2 rated)
// - Internal forward/reverse limits 0-8000, default 6000
// - External forward/reverse limits, default 6000
// - Source 0..3, changed only while stopped
// - External source follows the select input
// - Voltage limit is mV/10000 times scale
// - Current limit is (mA-12)/8 times scale
// - Analog limits capped at maximum motor speed
// - Analog scales 0-20000, default 3000
// - Speed-limited in speed mode while speed exceeds active limit
// - Speed-limited judged in every running state
// - Rotating and synchronized compares use filtered speed, 0.1ms units
// - Rotating when filtered speed reaches threshold
// - Synchronized when filtered error within threshold
// - Synchronized forced off unless running speed mode
// - Status reaches pins via mapping and polarity
// - Synchronization threshold 0-1000, default 10
module spdl_core #(
    parameter int unsigned NUM_DO = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic signed [15:0] speed_ref_i,
    input wire logic signed [15:0] speed_fb_i,
    input wire logic [15:0] rated_speed_i,
    input wire logic signed [15:0] voltage_analog_input_i,
    input wire logic [15:0] current_analog_input_i,
    input wire logic drive_running_i,
    input wire logic speed_mode_i,
    input wire logic external_limit_select_input_i,
    output logic signed [15:0] speed_ref_lim_o,
    output logic motor_overspeed_fault_o,
    output logic [NUM_DO-1:0] dout_o
);
    import spdl_pkg::*;

    localparam int unsigned DOCFG_W = NUM_DO * DO_FIELD_W;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            r[15:8] = dat[15:8];
        end
        return r;
    endfunction

    function automatic logic [15:0] sat16(input logic [15:0] v, input logic [15:0] mx);
        return (v > mx) ? mx : v;
    endfunction

    function automatic logic [15:0] abs16(input logic signed [15:0] v);
        return v[15] ? 16'(-v) : 16'(v);
    endfunction

    // ==========================================================
    // Register file and bus slave
    spdl_src_t src_q, src_d;
    logic [15:0] ifwd_q, ifwd_d, irev_q, irev_d, efwd_q, efwd_d, erev_q, erev_d;
    logic [15:0] vscl_q, vscl_d, iscl_q, iscl_d, rotthr_q, rotthr_d, synthr_q, synthr_d;
    logic [15:0] flt_q, flt_d, ovs_q, ovs_d;
    logic [DOCFG_W-1:0] docfg_q, docfg_d;
    logic fault_q, fault_d, ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic req, wr;
    logic [15:0] wv;
    logic overspeed;
    logic limited_q, rotating_q, synced_q;
    logic signed [15:0] fspd_q;

    always_comb begin
        req = wb_cyc_i & wb_stb_i & ~ack_q;
        wr = req & wb_we_i;
        ack_d = req;
        rdat_d = 32'h0000_0000;
        src_d = src_q;
        ifwd_d = ifwd_q;
        irev_d = irev_q;
        efwd_d = efwd_q;
        erev_d = erev_q;
        vscl_d = vscl_q;
        iscl_d = iscl_q;
        rotthr_d = rotthr_q;
        synthr_d = synthr_q;
        flt_d = flt_q;
        ovs_d = ovs_q;
        docfg_d = docfg_q;
        fault_d = fault_q;
        wv = 16'h0000;
        unique case (wb_adr_i)
            ADR_SRC: begin
                wv = merge16({14'h0000, src_q}, wb_dat_i, wb_sel_i);
                // Writes while running, or out of range, are dropped.
                if (wr && !drive_running_i && wv <= MAX_SRC) begin
                    src_d = spdl_src_t'(wv[1:0]);
                end
                rdat_d = {30'h0000_0000, src_q};
            end
            ADR_IFWD: begin
                wv = merge16(ifwd_q, wb_dat_i, wb_sel_i);
                if (wr) begin
                    ifwd_d = sat16(wv, MAX_LIMIT);
                end
                rdat_d = {16'h0000, ifwd_q};
            end
            ADR_IREV: begin
                wv = merge16(irev_q, wb_dat_i, wb_sel_i);
                if (wr) begin
                    irev_d = sat16(wv, MAX_LIMIT);
                end
                rdat_d = {16'h0000, irev_q};
            end
            ADR_EFWD: begin
                wv = merge16(efwd_q, wb_dat_i, wb_sel_i);
                if (wr) begin
                    efwd_d = sat16(wv, MAX_LIMIT);
                end
                rdat_d = {16'h0000, efwd_q};
            end
            ADR_EREV: begin
                wv = merge16(erev_q, wb_dat_i, wb_sel_i);
                if (wr) begin
                    erev_d = sat16(wv, MAX_LIMIT);
                end
                rdat_d = {16'h0000, erev_q};
            end
            ADR_VSCL: begin
                wv = merge16(vscl_q, wb_dat_i, wb_sel_i);
                if (wr) begin
                    vscl_d = sat16(wv, MAX_SCALE);
                end
                rdat_d = {16'h0000, vscl_q};
            end
            ADR_ISCL: begin
                wv = merge16(iscl_q, wb_dat_i, wb_sel_i);
                if (wr) begin
                    iscl_d = sat16(wv, MAX_SCALE);
                end
                rdat_d = {16'h0000, iscl_q};
            end
            ADR_ROT: begin
                wv = merge16(rotthr_q, wb_dat_i, wb_sel_i);
                if (wr) begin
                    rotthr_d = sat16(wv, MAX_THR);
                end
                rdat_d = {16'h0000, rotthr_q};
            end
            ADR_SYN: begin
                wv = merge16(synthr_q, wb_dat_i, wb_sel_i);
                if (wr) begin
                    synthr_d = sat16(wv, MAX_THR);
                end
                rdat_d = {16'h0000, synthr_q};
            end
            ADR_FLT: begin
                wv = merge16(flt_q, wb_dat_i, wb_sel_i);
                if (wr) begin
                    flt_d = sat16(wv, MAX_THR);
                end
                rdat_d = {16'h0000, flt_q};
            end
            ADR_OVS: begin
                wv = merge16(ovs_q, wb_dat_i, wb_sel_i);
                if (wr) begin
                    ovs_d = wv;
                end
                rdat_d = {16'h0000, ovs_q};
            end
            ADR_DOCFG: begin
                wv = merge16(16'(docfg_q), wb_dat_i, wb_sel_i);
                if (wr) begin
                    docfg_d = wv[DOCFG_W-1:0];
                end
                rdat_d = {16'h0000, 16'(docfg_q)};
            end
            ADR_STAT: begin
                if (wr && wb_sel_i[0] && wb_dat_i[STAT_FAULT]) begin
                    fault_d = 1'b0;
                end
                rdat_d = {28'h000_0000, synced_q, rotating_q, limited_q, fault_q};
            end
            ADR_FSPD: begin
                rdat_d = {{16{fspd_q[15]}}, fspd_q};
            end
            default: begin
                rdat_d = 32'h0000_0000;
            end
        endcase
        // A fault in the same cycle as its clear still latches.
        if (overspeed) begin
            fault_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_q <= SRC_INTERNAL;
            ifwd_q <= RST_LIMIT;
            irev_q <= RST_LIMIT;
            efwd_q <= RST_LIMIT;
            erev_q <= RST_LIMIT;
            vscl_q <= RST_SCALE;
            iscl_q <= RST_SCALE;
            rotthr_q <= RST_ROT;
            synthr_q <= RST_SYN;
            flt_q <= RST_FLT;
            ovs_q <= RST_OVS;
            docfg_q <= '0;
            fault_q <= 1'b0;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            src_q <= src_d;
            ifwd_q <= ifwd_d;
            irev_q <= irev_d;
            efwd_q <= efwd_d;
            erev_q <= erev_d;
            vscl_q <= vscl_d;
            iscl_q <= iscl_d;
            rotthr_q <= rotthr_d;
            synthr_q <= synthr_d;
            flt_q <= flt_d;
            ovs_q <= ovs_d;
            docfg_q <= docfg_d;
            fault_q <= fault_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign motor_overspeed_fault_o = fault_q;

    // ==========================================================
    // Limit selection and clamping
    logic [31:0] maxspd, volt_lim, cur_lim, cur_excess;
    logic [15:0] fb_abs, ovs_lvl, ana_lim, fwd_lim, rev_lim;
    logic ext_s1_q, ext_s2_q;

    always_comb begin
        maxspd = 32'(rated_speed_i) * MAXSPD_NUM / MAXSPD_DEN;
        // Negative samples give a zero limit rather than a reversed one.
        volt_lim = voltage_analog_input_i[15] ? 32'h0000_0000 :
                   32'(voltage_analog_input_i) * 32'(vscl_q) / VOLT_FULL_MV;
        cur_excess = (32'(current_analog_input_i) > CUR_OFS_MA * CUR_UA_PER_MA) ?
                     32'(current_analog_input_i) - CUR_OFS_MA * CUR_UA_PER_MA : 32'h0000_0000;
        cur_lim = cur_excess * 32'(iscl_q) / (CUR_SPAN_MA * CUR_UA_PER_MA);
        ana_lim = 16'h0000;
        if (src_q == SRC_VOLTAGE) begin
            ana_lim = (volt_lim > maxspd) ? 16'(maxspd) : 16'(volt_lim);
        end else if (src_q == SRC_CURRENT) begin
            ana_lim = (cur_lim > maxspd) ? 16'(maxspd) : 16'(cur_lim);
        end
        unique case (src_q)
            SRC_INTERNAL: begin
                fwd_lim = ifwd_q;
                rev_lim = irev_q;
            end
            SRC_EXTERNAL: begin
                fwd_lim = ext_s2_q ? efwd_q : ifwd_q;
                rev_lim = ext_s2_q ? erev_q : irev_q;
            end
            SRC_VOLTAGE, SRC_CURRENT: begin
                fwd_lim = ana_lim;
                rev_lim = ana_lim;
            end
        endcase
        fb_abs = abs16(speed_fb_i);
        ovs_lvl = (32'(ovs_q) < maxspd) ? ovs_q : 16'(maxspd);
        overspeed = fb_abs > ovs_lvl;
    end

    // ==========================================================
    // Speed feedback filter and status
    logic [$clog2(FILT_UNIT_CYC)-1:0] tick_q, tick_d;
    logic signed [15:0] fspd_d, ref_lim_d, ref_lim_q;
    logic signed [16:0] ferr;
    logic [15:0] fabs, serr;
    logic limited_d, rotating_d, synced_d;
    logic [NUM_DO-1:0] dout_d, dout_q;
    logic [1:0] fn;

    always_comb begin
        tick_d = (32'(tick_q) == FILT_UNIT_CYC - 1) ? '0 : tick_q + 1'b1;
        ferr = 17'(speed_fb_i) - 17'(fspd_q);
        fspd_d = fspd_q;
        // Dividing by the time constant plus one, once per 0.1ms unit, keeps a time constant of zero a pass-through.
        if (32'(tick_q) == FILT_UNIT_CYC - 1) begin
            fspd_d = 16'(fspd_q + 16'(ferr / $signed({7'h00, flt_q[9:0]} + 17'sh1)));
        end
        if (speed_ref_i > $signed(fwd_lim)) begin
            ref_lim_d = $signed(fwd_lim);
        end else if (speed_ref_i < -$signed(rev_lim)) begin
            ref_lim_d = -$signed(rev_lim);
        end else begin
            ref_lim_d = speed_ref_i;
        end
        // Judged regardless of enable; only the control mode gates it.
        limited_d = speed_mode_i &&
                    (speed_fb_i[15] ? fb_abs > rev_lim : fb_abs > fwd_lim);
        fabs = abs16(fspd_q);
        rotating_d = fabs >= rotthr_q;
        serr = abs16(16'(fspd_q - speed_ref_i));
        synced_d = drive_running_i && speed_mode_i && serr <= synthr_q;
        for (int i = 0; i < NUM_DO; i++) begin
            fn = docfg_q[i*DO_FIELD_W +: 2];
            unique case (spdl_fn_t'(fn))
                FN_NONE: dout_d[i] = 1'b0;
                FN_LIMITED: dout_d[i] = limited_q;
                FN_ROTATING: dout_d[i] = rotating_q;
                FN_SYNCED: dout_d[i] = synced_q;
            endcase
            dout_d[i] = dout_d[i] ^ docfg_q[i*DO_FIELD_W+DO_POL_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            tick_q <= '0;
            fspd_q <= 16'sh0000;
            ref_lim_q <= 16'sh0000;
            limited_q <= 1'b0;
            rotating_q <= 1'b0;
            synced_q <= 1'b0;
            dout_q <= '0;
        end else begin
            ext_s1_q <= external_limit_select_input_i;
            ext_s2_q <= ext_s1_q;
            tick_q <= tick_d;
            fspd_q <= fspd_d;
            ref_lim_q <= ref_lim_d;
            limited_q <= limited_d;
            rotating_q <= rotating_d;
            synced_q <= synced_d;
            dout_q <= dout_d;
        end
    end

    assign speed_ref_lim_o = ref_lim_q;
    assign dout_o = dout_q;

endmodule

`default_nettype wire

/* File: inc/spdl_pkg.sv */
// Constants, register map and encodings of the speed limit and speed status block.
// Assumes a 20 MHz control clock and speeds given in signed rpm.
package spdl_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned FILT_UNIT_NS = 100_000;
    localparam int unsigned FILT_UNIT_CYC = FILT_UNIT_NS * (CLK_HZ / 1_000_000) / 1000;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADR_SRC = 8'h00;
    localparam logic [7:0] ADR_IFWD = 8'h04;
    localparam logic [7:0] ADR_IREV = 8'h08;
    localparam logic [7:0] ADR_EFWD = 8'h0C;
    localparam logic [7:0] ADR_EREV = 8'h10;
    localparam logic [7:0] ADR_VSCL = 8'h14;
    localparam logic [7:0] ADR_ISCL = 8'h18;
    localparam logic [7:0] ADR_ROT = 8'h1C;
    localparam logic [7:0] ADR_SYN = 8'h20;
    localparam logic [7:0] ADR_FLT = 8'h24;
    localparam logic [7:0] ADR_OVS = 8'h28;
    localparam logic [7:0] ADR_DOCFG = 8'h2C;
    localparam logic [7:0] ADR_STAT = 8'h30;
    localparam logic [7:0] ADR_FSPD = 8'h34;

    // ==========================================================
    // Reset values and ranges
    localparam logic [15:0] RST_LIMIT = 16'h1770;
    localparam logic [15:0] RST_SCALE = 16'h0BB8;
    localparam logic [15:0] RST_ROT = 16'h0014;
    localparam logic [15:0] RST_SYN = 16'h000A;
    localparam logic [15:0] RST_FLT = 16'h0064;
    localparam logic [15:0] RST_OVS = 16'h2710;
    localparam logic [15:0] MAX_LIMIT = 16'h1F40;
    localparam logic [15:0] MAX_SCALE = 16'h4E20;
    localparam logic [15:0] MAX_THR = 16'h03E8;
    localparam logic [15:0] MAX_SRC = 16'h0003;

    // ==========================================================
    // Scaling of maximum speed and analog inputs
    localparam logic [31:0] MAXSPD_NUM = 32'h0000_000C;
    localparam logic [31:0] MAXSPD_DEN = 32'h0000_000A;
    localparam logic [31:0] VOLT_FULL_MV = 32'h0000_2710;
    localparam logic [31:0] CUR_UA_PER_MA = 32'h0000_03E8;
    localparam logic [31:0] CUR_OFS_MA = 32'h0000_000C;
    localparam logic [31:0] CUR_SPAN_MA = 32'h0000_0008;

    // ==========================================================
    // Status bits and output configuration fields
    localparam int unsigned STAT_FAULT = 0;
    localparam int unsigned STAT_LIMITED = 1;
    localparam int unsigned STAT_ROT = 2;
    localparam int unsigned STAT_SYNC = 3;
    localparam int unsigned DO_FIELD_W = 3;
    localparam int unsigned DO_POL_BIT = 2;

    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'b00,
        SRC_EXTERNAL = 2'b01,
        SRC_VOLTAGE = 2'b10,
        SRC_CURRENT = 2'b11
    } spdl_src_t;

    typedef enum logic [1:0] {
        FN_NONE = 2'b00,
        FN_LIMITED = 2'b01,
        FN_ROTATING = 2'b10,
        FN_SYNCED = 2'b11
    } spdl_fn_t;

endpackage

/* File: verification/spdl_core_sva.sv */
// Checker of the speed limit block, bound to every spdl_core.
// Assumes only the core's ports; the pin map is shadowed from bus writes.
`timescale 1ns/100ps
`default_nettype none
module spdl_core_sva
    import spdl_pkg::*;
#(
    parameter int unsigned NUM_DO = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic signed [15:0] speed_ref_i,
    input wire logic signed [15:0] speed_fb_i,
    input wire logic [15:0] rated_speed_i,
    input wire logic drive_running_i,
    input wire logic speed_mode_i,
    input wire logic signed [15:0] speed_ref_lim_o,
    input wire logic [NUM_DO-1:0] dout_o,
    input wire logic motor_overspeed_fault_o
);
    // ==========
    // Shadow of the pin map and speed figures
    logic [15:0] cfg_d, cfg_q;
    logic [31:0] fb_abs, max_spd;
    logic [NUM_DO-1:0] sync_m, lim_m, none_m, none_p;
    always_comb begin
        cfg_d = cfg_q;
        if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == ADR_DOCFG) begin
            if (wb_sel_i[0]) begin
                cfg_d[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                cfg_d[15:8] = wb_dat_i[15:8];
            end
        end
        if (rst_i) begin
            cfg_d = 16'h0000;
        end
        fb_abs = speed_fb_i[15] ? -32'(speed_fb_i) : 32'(speed_fb_i);
        max_spd = 32'(rated_speed_i) * MAXSPD_NUM / MAXSPD_DEN;
        for (int i = 0; i < NUM_DO; i++) begin
            sync_m[i] = cfg_q[3*i +: 3] == 3'h3;
            lim_m[i] = cfg_q[3*i +: 3] == 3'h1;
            none_m[i] = cfg_q[3*i +: 2] == 2'h0;
            none_p[i] = cfg_q[3*i+2];
        end
    end
    always_ff @(posedge clk_i) begin
        cfg_q <= cfg_d;
    end

    // ==========
    // Properties
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Three steady cycles span the status and pin registers.
    sequence s_hold(c);
        (c && $stable(cfg_q))[*3];
    endsequence
    ack_resp_a: assert property (s_take |=> wb_ack_o)
        else $error("no ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("stray ack");
    clamp_fwd_a: assert property ((speed_ref_i >= 0) |=>
        (speed_ref_lim_o >= 0 && speed_ref_lim_o <= $past(speed_ref_i)))
        else $error("fwd not clamped");
    clamp_rev_a: assert property ((speed_ref_i <= 0) |=>
        (speed_ref_lim_o <= 0 && speed_ref_lim_o >= $past(speed_ref_i)))
        else $error("rev not clamped");
    ovs_fault_a: assert property ((fb_abs > max_spd) |=> motor_overspeed_fault_o)
        else $error("no overspeed fault");
    sync_off_a: assert property (s_hold(!drive_running_i || !speed_mode_i) |->
        (dout_o & sync_m) == '0)
        else $error("sync pin while idle");
    lim_off_a: assert property (s_hold(!speed_mode_i) |-> (dout_o & lim_m) == '0)
        else $error("limited pin off mode");
    none_pin_a: assert property (s_hold(1'b1) |-> ((dout_o ^ none_p) & none_m) == '0)
        else $error("unmapped pin level");
endmodule

bind spdl_core spdl_core_sva #(.NUM_DO(NUM_DO)) spdl_core_sva_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .speed_ref_i(speed_ref_i), .speed_fb_i(speed_fb_i), .rated_speed_i(rated_speed_i),
    .drive_running_i(drive_running_i), .speed_mode_i(speed_mode_i),
    .speed_ref_lim_o(speed_ref_lim_o), .dout_o(dout_o),
    .motor_overspeed_fault_o(motor_overspeed_fault_o)
);
`default_nettype wire

/* File: verification/spdl_host_mdl.sv */
// Host controller model that scans the drive's digital outputs.
// Assumes the pins are sampled once per control clock, as a host input port would.
`timescale 1ns/100ps
`default_nettype none
module spdl_host_mdl #(
    parameter int unsigned NUM_DO = 4
) (
    input wire logic clk_i,
    input wire logic [NUM_DO-1:0] pins_i,
    output logic [NUM_DO-1:0] seen_o
);
    always_ff @(posedge clk_i) begin
        seen_o <= pins_i;
    end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench of the speed limit block: bus, speed path and status pins.
// Assumes a host model scanning the pins one cycle behind the core.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import spdl_pkg::*;
    localparam int LIMIT = 60000;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic wb_ack_o, motor_overspeed_fault_o, drive_running_i = 1'b0, speed_mode_i = 1'b1;
    logic external_limit_select_input_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0, dout_o, seen;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic signed [15:0] speed_ref_i = 16'sh0, speed_fb_i = 16'sh0, speed_ref_lim_o;
    logic signed [15:0] voltage_analog_input_i = 16'sh0;
    logic [15:0] rated_speed_i = 16'h1388, current_analog_input_i = 16'h0;
    int n_errors = 0, checked = 0, cycles = 0;

    spdl_core spdl_core_inst (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .speed_ref_i(speed_ref_i), .speed_fb_i(speed_fb_i), .rated_speed_i(rated_speed_i),
        .voltage_analog_input_i(voltage_analog_input_i),
        .current_analog_input_i(current_analog_input_i),
        .drive_running_i(drive_running_i), .speed_mode_i(speed_mode_i),
        .external_limit_select_input_i(external_limit_select_input_i),
        .speed_ref_lim_o(speed_ref_lim_o), .motor_overspeed_fault_o(motor_overspeed_fault_o),
        .dout_o(dout_o));
    spdl_host_mdl spdl_host_mdl_inst (.clk_i(clk_i), .pins_i(dout_o),
        .seen_o(seen));

    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            test_done();
        end
    end

    // ==========
    // Shared tasks
    task automatic test_done;
        $display("Errors %0d of %0d checks", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(nm, exp, r);
    endtask
    task automatic drv(input logic signed [15:0] rf, input logic signed [15:0] fb, input int n);
        @(posedge clk_i);
        speed_ref_i <= rf;
        speed_fb_i <= fb;
        repeat (n) @(posedge clk_i);
    endtask
    task automatic clim(input string nm, input logic signed [15:0] rf,
                        input logic signed [15:0] ex);
        drv(rf, 16'sh0, 4);
        chk(nm, 32'(ex), 32'(speed_ref_lim_o));
    endtask

    // ==========
    // Scenarios
    task automatic t_defaults;
        logic [7:0] a [11] = '{ADR_SRC, ADR_IFWD, ADR_IREV, ADR_EFWD, ADR_EREV, ADR_VSCL,
            ADR_ISCL, ADR_ROT, ADR_SYN, ADR_FLT, 8'h3C};
        logic [31:0] e [11] = '{32'h0, 32'h1770, 32'h1770, 32'h1770, 32'h1770, 32'hBB8,
            32'hBB8, 32'h14, 32'hA, 32'h64, 32'h0};
        wr(8'h3C, 32'h1234);
        for (int i = 0; i < 11; i++) begin
            rdc("reset value", a[i], e[i]);
        end
        wr(ADR_IFWD, 32'hFFFF_FFFF);
        rdc("fwd max", ADR_IFWD, 32'h1F40);
        wr(ADR_VSCL, 32'hFFFF_FFFF);
        rdc("scale max", ADR_VSCL, 32'h4E20);
        wr(ADR_SYN, 32'hFFFF_FFFF);
        rdc("sync max", ADR_SYN, 32'h3E8);
    endtask
    task automatic t_limits;
        logic signed [15:0] rf [5] = '{16'sh5DC, -16'sh320, 16'sh12C, 16'sh3E8, -16'sh1F5};
        logic signed [15:0] ex [5] = '{16'sh3E8, -16'sh1F4, 16'sh12C, 16'sh3E8, -16'sh1F4};
        wr(ADR_IFWD, 32'h3E8);
        wr(ADR_IREV, 32'h1F4);
        for (int i = 0; i < 5; i++) begin
            clim("internal clamp", rf[i], ex[i]);
        end
        wr(ADR_SRC, 32'h1);
        wr(ADR_EFWD, 32'h2BC);
        wr(ADR_EREV, 32'h12C);
        clim("select low", 16'sh5DC, 16'sh3E8);
        external_limit_select_input_i <= 1'b1;
        clim("ext fwd", 16'sh5DC, 16'sh2BC);
        clim("ext rev", -16'sh384, -16'sh12C);
        drive_running_i <= 1'b1;
        wr(ADR_SRC, 32'h2);
        rdc("source running", ADR_SRC, 32'h1);
        drive_running_i <= 1'b0;
        wr(ADR_SRC, 32'h4);
        rdc("source range", ADR_SRC, 32'h1);
        wr(ADR_SRC, 32'h2);
        wr(ADR_VSCL, 32'hBB8);
        voltage_analog_input_i <= 16'sh1388;
        clim("volt limit", 16'shFA0, 16'sh5DC);
        voltage_analog_input_i <= 16'sh7530;
        clim("volt cap", 16'sh1B58, 16'sh1770);
        wr(ADR_SRC, 32'h3);
        current_analog_input_i <= 16'h3E80;
        clim("cur limit", 16'sh7D0, 16'sh5DC);
        current_analog_input_i <= 16'h9C40;
        clim("cur cap", -16'sh1B58, -16'sh1770);
        wr(ADR_SRC, 32'h0);
    endtask
    task automatic t_filter;
        logic [31:0] r;
        int t0;
        wr(ADR_FLT, 32'h0);
        drv(16'sh0, 16'sh3E8, 2100);
        rdc("filtered", ADR_FSPD, 32'h3E8);
        wr(ADR_FLT, 32'h1);
        drv(16'sh0, 16'sh0, 0);
        for (int k = 0; k < 2; k++) begin
            t0 = cycles;
            r = 32'h3E8 >> k;
            for (int i = 0; i < 1000 && r == (32'h3E8 >> k); i++) begin
                xfer(1'b0, ADR_FSPD, 32'h0, r);
            end
            chk("filter step", 32'h1F4 >> k, r);
        end
        chk("filter period", 32'h1, 32'(cycles - t0 > 1990 && cycles - t0 < 2010));
    endtask
    task automatic t_status;
        wr(ADR_DOCFG, 32'h8F1);
        wr(ADR_SYN, 32'hA);
        wr(ADR_FLT, 32'h0);
        drv(16'sh5DC, 16'sh5DC, 2100);
        chk("pins stopped", 32'h9, 32'(seen));
        drive_running_i <= 1'b1;
        drv(16'sh5DC, 16'sh5DC, 4);
        chk("pins synced", 32'hD, 32'(seen));
        rdc("status", ADR_STAT, 32'hE);
        drv(16'sh5E7, 16'sh5DC, 4);
        chk("sync off", 32'h9, 32'(seen));
        drv(16'sh5E6, 16'sh5DC, 4);
        chk("sync edge", 32'hD, 32'(seen));
        speed_mode_i <= 1'b0;
        drv(16'sh5E6, 16'sh5DC, 4);
        chk("other mode", 32'h8, 32'(seen));
        speed_mode_i <= 1'b1;
        drive_running_i <= 1'b0;
        drv(16'sh0, 16'sh14, 2100);
        chk("rot edge", 32'h8, 32'(seen));
        drv(16'sh0, 16'sh13, 2100);
        chk("rot off", 32'hA, 32'(seen));
        rated_speed_i <= 16'h7D0;
        drv(16'sh0, 16'sh960, 3);
        chk("at max", 32'h0, 32'(motor_overspeed_fault_o));
        drv(16'sh0, -16'sh961, 3);
        chk("above max", 32'h1, 32'(motor_overspeed_fault_o));
        drv(16'sh0, 16'sh0, 3);
        chk("fault held", 32'h1, 32'(motor_overspeed_fault_o));
        wr(ADR_STAT, 32'h1);
        drv(16'sh0, 16'sh0, 2);
        chk("fault clear", 32'h0, 32'(motor_overspeed_fault_o));
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_defaults();
        t_limits();
        t_filter();
        t_status();
        test_done();
    end
endmodule
`default_nettype wire
